/* File: logic/aut_pkg.sv */
// package: register map, field positions and carriers for the timer-baud serial port
package aut_pkg;
    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DATA   = 8'h04;
    localparam logic [7:0] ADDR_TIMER  = 8'h08;
    localparam logic [7:0] ADDR_IRQ    = 8'h0C;
    // control register fields
    localparam int CTRL_MODE   = 7;
    localparam int CTRL_MCE    = 5;
    localparam int CTRL_REN    = 4;
    localparam int CTRL_TB8    = 3;
    localparam int CTRL_RB8    = 2;
    localparam int CTRL_TI     = 1;
    localparam int CTRL_RI     = 0;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    // timer register fields
    localparam int TMR_RELOAD_LSB = 0;
    localparam int TMR_LOW_LSB    = 8;
    localparam int TMR_SRC_LSB    = 16;
    localparam int TMR_RUN        = 19;
    // baud timer clock sources
    localparam logic [2:0] SRC_SYS     = 3'h0;
    localparam logic [2:0] SRC_DIV4    = 3'h1;
    localparam logic [2:0] SRC_DIV12   = 3'h2;
    localparam logic [2:0] SRC_DIV48   = 3'h3;
    localparam logic [2:0] SRC_EXT8    = 3'h4;
    localparam logic [5:0] PRE_TOP4    = 6'h03;
    localparam logic [5:0] PRE_TOP12   = 6'h0B;
    localparam logic [5:0] PRE_TOP48   = 6'h2F;
    localparam logic [2:0] EXT_TOP8    = 3'h7;
    localparam logic [7:0] TMR_MAX     = 8'hFF;
    localparam logic [3:0] BITS_8MODE  = 4'h9;
    localparam logic [3:0] BITS_9MODE  = 4'hA;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {AUT_RX_IDLE, AUT_RX_START, AUT_RX_SHIFT} aut_rx_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx_buf;
        logic [7:0] reload;
        logic [7:0] low_cnt;
        logic [2:0] src_sel;
        logic       run;
        logic       irq_en;
    } aut_regs_t;
endpackage

/* File: logic/aut_uart.sv */
// serial port with timer-driven baud generation and AXI4-Lite register access
//
// Function
// - data offset reads the receive buffer, writes load the transmit register
// - completed byte sits in the buffer while the next byte shifts in
// - done flags stay set until software writes them to zero
// - interrupt output requests whenever a done flag is set and enabled
// - tx bit clock from low counter overflows, rx from hidden counter copy
// - both counters' overflows are divided by two for the bit rate
// - hidden rx counter runs with timer, same reload, reloads at start
// - bit rate is timer clock over (256 minus reload), halved
// - timer clock picks system, div 4, 12, 48, or external div 8
// - control bit 7 picks 8-bit or 9-bit frames
// - 8-bit frame is start, eight data bits lsb first, stop
// - 8-bit receive stores data in buffer, stop bit in ninth-bit flag
// - data write starts transmit; tx done sets at stop-bit start
// - receiver accepts frames only while receive enable is set
// - 8-bit load needs rx done clear and, if filtering, stop bit one
// - on overrun the buffer keeps its first byte, later frames dropped
// - 9-bit frame is start, eight data bits, ninth bit, stop
// - transmitted ninth bit comes from the tx ninth-bit flag
// - 9-bit receive stores ninth bit in flag and ignores stop bit
// - 9-bit load needs rx done clear and, if filtering, ninth bit one
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module aut_uart (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // AXI4-Lite write address, data and response
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // clock source and serial pins
    input  wire logic        ext_osc_i,
    input  wire logic        serial_rx_pin_i,
    output logic             serial_tx_pin_o,
    // port interrupt request
    output logic             irq_o
);

    typedef struct packed {
        aut_pkg::aut_regs_t     regs;
        // bus slave
        logic                   aw_held;
        logic [7:0]             aw_addr;
        logic                   w_held;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        // timer clock
        logic [5:0]             pre_cnt;
        logic [2:0]             ext_cnt;
        logic                   ext_s1;
        logic                   ext_s2;
        logic                   ext_s3;
        // rx hidden counter, overflow halving flags
        logic [7:0]             rx_cnt;
        logic                   tx_half;
        logic                   rx_half;
        // transmitter
        logic                   tx_busy;
        logic [10:0]            tx_shift;
        logic [3:0]             tx_left;
        logic                   tx_line;
        // receiver
        logic                   rx_s1;
        logic                   rx_s2;
        logic                   rx_prev;
        aut_pkg::aut_rx_state_t rx_state;
        logic [8:0]             rx_shift;
        logic [3:0]             rx_bits;
    } aut_state_t;

    aut_state_t st;
    aut_state_t next_st;

    logic tick;
    logic tx_ovf;
    logic rx_ovf;
    logic rx_bit_tick;
    logic tx_bit_tick;
    logic wr_fire;
    logic rd_fire;

    always_comb begin
        next_st = st;
        tick = 1'b0;
        tx_ovf = 1'b0;
        rx_ovf = 1'b0;
        rx_bit_tick = 1'b0;
        tx_bit_tick = 1'b0;
        wr_fire = 1'b0;
        rd_fire = 1'b0;

        // =====================================================================
        // timer input clock
        next_st.ext_s1 = ext_osc_i;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_s3 = st.ext_s2;
        next_st.pre_cnt = st.pre_cnt + 6'h01;
        if (st.ext_s2 && !st.ext_s3) begin
            next_st.ext_cnt = st.ext_cnt + 3'h1;
        end
        unique case (st.regs.src_sel)
            aut_pkg::SRC_SYS: tick = 1'b1;
            aut_pkg::SRC_DIV4: tick = (st.pre_cnt[1:0] == aut_pkg::PRE_TOP4[1:0]);
            aut_pkg::SRC_DIV12: tick = (st.pre_cnt >= aut_pkg::PRE_TOP12);
            aut_pkg::SRC_DIV48: tick = (st.pre_cnt == aut_pkg::PRE_TOP48);
            aut_pkg::SRC_EXT8: tick = st.ext_s2 && !st.ext_s3 && (st.ext_cnt == aut_pkg::EXT_TOP8);
            default: tick = 1'b0;
        endcase
        if ((st.regs.src_sel == aut_pkg::SRC_DIV12 && st.pre_cnt >= aut_pkg::PRE_TOP12) ||
            st.pre_cnt == aut_pkg::PRE_TOP48) begin
            next_st.pre_cnt = '0;
        end

        // =====================================================================
        // baud counters: auto reload, rate = clk / (256 - reload) / 2
        if (st.regs.run && tick) begin
            if (st.regs.low_cnt == aut_pkg::TMR_MAX) begin
                tx_ovf = 1'b1;
                next_st.regs.low_cnt = st.regs.reload;
            end else begin
                next_st.regs.low_cnt = st.regs.low_cnt + 8'h01;
            end
            if (st.rx_cnt == aut_pkg::TMR_MAX) begin
                rx_ovf = 1'b1;
                next_st.rx_cnt = st.regs.reload;
            end else begin
                next_st.rx_cnt = st.rx_cnt + 8'h01;
            end
        end
        if (tx_ovf) begin
            next_st.tx_half = !st.tx_half;
            tx_bit_tick = st.tx_half;
        end
        if (rx_ovf) begin
            next_st.rx_half = !st.rx_half;
            rx_bit_tick = st.rx_half;
        end

        // =====================================================================
        // transmitter
        if (st.tx_busy && tx_bit_tick) begin
            next_st.tx_line = st.tx_shift[0];
            next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
            next_st.tx_left = st.tx_left - 4'h1;
            if (st.tx_left == 4'h1) begin
                next_st.regs.ctrl[aut_pkg::CTRL_TI] = 1'b1;
            end
            if (st.tx_left == 4'h0) begin
                next_st.tx_busy = 1'b0;
                next_st.tx_line = 1'b1;
            end
        end

        // =====================================================================
        // receiver
        next_st.rx_s1 = serial_rx_pin_i;
        next_st.rx_s2 = st.rx_s1;
        next_st.rx_prev = st.rx_s2;
        unique case (st.rx_state)
            aut_pkg::AUT_RX_IDLE: begin
                if (st.regs.ctrl[aut_pkg::CTRL_REN] && st.rx_prev && !st.rx_s2) begin
                    next_st.rx_cnt = st.regs.reload;
                    next_st.rx_half = 1'b0;
                    next_st.rx_bits = '0;
                    next_st.rx_state = aut_pkg::AUT_RX_START;
                end
            end
            aut_pkg::AUT_RX_START: begin
                // first overflow lands mid start bit
                if (rx_ovf && !st.rx_half) begin
                    next_st.rx_state = st.rx_s2 ? aut_pkg::AUT_RX_IDLE : aut_pkg::AUT_RX_SHIFT;
                    next_st.rx_half = 1'b0;
                end
            end
            aut_pkg::AUT_RX_SHIFT: begin
                if (rx_bit_tick) begin
                    next_st.rx_shift = {st.rx_s2, st.rx_shift[8:1]};
                    next_st.rx_bits = st.rx_bits + 4'h1;
                    if (st.rx_bits == (st.regs.ctrl[aut_pkg::CTRL_MODE]
                                       ? aut_pkg::BITS_9MODE : aut_pkg::BITS_8MODE) - 4'h1) begin
                        next_st.rx_state = aut_pkg::AUT_RX_IDLE;
                        // 8-bit: stop bit is bit 8; 9-bit: ninth bit, stop ignored
                        if (!st.regs.ctrl[aut_pkg::CTRL_RI] &&
                            (!st.regs.ctrl[aut_pkg::CTRL_MCE] ||
                             (st.regs.ctrl[aut_pkg::CTRL_MODE] ? st.rx_shift[8] : st.rx_s2))) begin
                            if (st.regs.ctrl[aut_pkg::CTRL_MODE]) begin
                                next_st.regs.rx_buf = st.rx_shift[7:0];
                                next_st.regs.ctrl[aut_pkg::CTRL_RB8] = st.rx_shift[8];
                            end else begin
                                next_st.regs.rx_buf = {st.rx_shift[8:1]};
                                next_st.regs.ctrl[aut_pkg::CTRL_RB8] = st.rx_s2;
                            end
                            next_st.regs.ctrl[aut_pkg::CTRL_RI] = 1'b1;
                        end
                    end
                end
            end
            default: next_st.rx_state = aut_pkg::AUT_RX_IDLE;
        endcase

        // =====================================================================
        // AXI4-Lite slave
        if (s_axi_awvalid_i && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata_i;
            next_st.w_strb = s_axi_wstrb_i;
        end
        wr_fire = st.aw_held && st.w_held && !st.bvalid;
        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = aut_pkg::RESP_OKAY;
            unique case (st.aw_addr)
                aut_pkg::ADDR_CTRL: if (st.w_strb[0]) begin
                    // flags: software clears; a same-cycle set wins
                    next_st.regs.ctrl = {st.w_data[7], 1'b0, st.w_data[5:2],
                        next_st.regs.ctrl[aut_pkg::CTRL_TI] | st.w_data[1],
                        next_st.regs.ctrl[aut_pkg::CTRL_RI] | st.w_data[0]} |
                        (aut_pkg::CTRL_RESET & 8'h00);
                    if (!st.w_data[1] && !(tx_bit_tick && st.tx_busy && st.tx_left == 4'h1)) begin
                        next_st.regs.ctrl[aut_pkg::CTRL_TI] = 1'b0;
                    end
                    if (!st.w_data[0] && next_st.regs.ctrl[aut_pkg::CTRL_RI] == st.regs.ctrl[aut_pkg::CTRL_RI]) begin
                        next_st.regs.ctrl[aut_pkg::CTRL_RI] = 1'b0;
                    end
                end
                aut_pkg::ADDR_DATA: if (st.w_strb[0] && !st.tx_busy) begin
                    next_st.tx_busy = 1'b1;
                    next_st.tx_line = 1'b1;
                    next_st.tx_half = 1'b0;
                    next_st.tx_shift = st.regs.ctrl[aut_pkg::CTRL_MODE]
                        ? {1'b1, st.regs.ctrl[aut_pkg::CTRL_TB8], st.w_data[7:0], 1'b0}
                        : {2'b11, st.w_data[7:0], 1'b0};
                    next_st.tx_left = (st.regs.ctrl[aut_pkg::CTRL_MODE]
                        ? aut_pkg::BITS_9MODE : aut_pkg::BITS_8MODE) + 4'h1;
                end
                aut_pkg::ADDR_TIMER: begin
                    if (st.w_strb[0]) next_st.regs.reload = st.w_data[7:0];
                    if (st.w_strb[1]) next_st.regs.low_cnt = st.w_data[15:8];
                    if (st.w_strb[2]) begin
                        next_st.regs.src_sel = st.w_data[aut_pkg::TMR_SRC_LSB +: 3];
                        next_st.regs.run = st.w_data[aut_pkg::TMR_RUN];
                    end
                end
                aut_pkg::ADDR_IRQ: if (st.w_strb[0]) next_st.regs.irq_en = st.w_data[0];
                default: next_st.bresp = aut_pkg::RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        rd_fire = s_axi_arvalid_i && !st.rvalid;
        if (rd_fire) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = aut_pkg::RESP_OKAY;
            next_st.rdata = '0;
            unique case (s_axi_araddr_i)
                aut_pkg::ADDR_CTRL: next_st.rdata[7:0] = st.regs.ctrl;
                aut_pkg::ADDR_DATA: next_st.rdata[7:0] = st.regs.rx_buf;
                aut_pkg::ADDR_TIMER: next_st.rdata = {12'h000, st.regs.run, st.regs.src_sel,
                                                     st.regs.low_cnt, st.regs.reload};
                aut_pkg::ADDR_IRQ: next_st.rdata[0] = st.regs.irq_en;
                default: next_st.rresp = aut_pkg::RESP_SLVERR;
            endcase
        end else if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.regs.ctrl <= aut_pkg::CTRL_RESET;
            st.tx_line <= 1'b1;
            st.rx_s1 <= 1'b1;
            st.rx_s2 <= 1'b1;
            st.rx_prev <= 1'b1;
            st.rx_state <= aut_pkg::AUT_RX_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // =========================================================================
    // outputs
    assign s_axi_awready_o = !st.aw_held;
    assign s_axi_wready_o = !st.w_held;
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_arready_o = !st.rvalid;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;
    assign serial_tx_pin_o = st.tx_line;
    assign irq_o = st.regs.irq_en &&
                   (st.regs.ctrl[aut_pkg::CTRL_TI] || st.regs.ctrl[aut_pkg::CTRL_RI]);

endmodule // aut_uart

/* File: verification/aut_remote.sv */
// remote serial transceiver model on the port's pins
`timescale 1ns/1ps
module aut_remote (
    input  wire logic core_clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    logic [9:0] word;
    int         frames = 0;
    int         bit_cyc = 16;
    initial line_o = 1'b1;
    // ten samples mid-bit after each start edge
    always begin
        @(negedge line_i);
        repeat (bit_cyc / 2) @(posedge core_clk_i);
        for (int i = 0; i < 10; i++) begin
            repeat (bit_cyc) @(posedge core_clk_i);
            word[i] = line_i;
        end
        frames++;
    end
    // start bit, n bits lsb first, then idle high
    task automatic send(input logic [9:0] bits, input int n);
        @(posedge core_clk_i);
        line_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (bit_cyc) @(posedge core_clk_i);
            line_o <= bits[i];
        end
        repeat (bit_cyc) @(posedge core_clk_i);
        line_o <= 1'b1;
        repeat (bit_cyc) @(posedge core_clk_i);
    endtask
endmodule // aut_remote

/* File: verification/aut_uart_asserts.sv */
// checker: bus handshake, interrupt and serial pin assertions
`timescale 1ns/1ps
module aut_uart_asserts (
    input wire logic        core_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        serial_tx_pin_o,
    input wire logic        irq_o
);
    // ========================
    // assertions
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    wr_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
        $stable(s_axi_bresp_o)) else $error("write response dropped");
    wr_lat_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
        s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write response late");
    rd_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response late");
    rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
        $stable(s_axi_rdata_o)) else $error("read data dropped");
    rd_cause_a: assert property ($rose(s_axi_rvalid_o) |-> $past(s_axi_arvalid_i) &&
        $past(s_axi_arready_o)) else $error("read response without request");
    start_len_a: assert property ($fell(serial_tx_pin_o) |=> !serial_tx_pin_o)
        else $error("start bit shorter than two cycles");
    irq_drop_a: assert property ($fell(irq_o) |-> ##[0:1] s_axi_bvalid_o)
        else $error("interrupt dropped without software write");
    tx_idle_a: assert property ($fell(sys_rst_i) |-> serial_tx_pin_o && !irq_o)
        else $error("line not idle after reset");
    cover property ($rose(irq_o));
    cover property ($fell(serial_tx_pin_o));
    cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // aut_uart_asserts

bind aut_uart aut_uart_asserts u_chk (.*);

/* File: verification/aut_uart_tb.sv */
// testbench: register, transmit and receive checks of the serial port
`timescale 1ns/1ps
module aut_uart_tb;
    logic        clk, rst, ext, awv, wv, br, arv, rr, m, b9, eb9, edn;
    logic        awrdy, wrdy, bv, arrdy, rv, tx, rx, irq;
    logic [7:0]  awa, ara, d, rl, eb;
    logic [31:0] wd, rd, rd_d, seed;
    logic [1:0]  bresp, rresp, rd_r, wr_r;
    logic [5:0]  c;
    int          errors, n_checks, f;
    int          dv[5] = '{1, 4, 12, 48, 64};
    logic [5:0]  cs[8] = '{6'h01, 6'h05, 6'h25, 6'h0C, 6'h04, 6'h1D, 6'h1E, 6'h15};
    aut_uart dut (
        .core_clk_i(clk), .sys_rst_i(rst),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arrdy), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .ext_osc_i(ext),
        .serial_rx_pin_i(rx), .serial_tx_pin_o(tx), .irq_o(irq)
    );
    aut_remote rem (.core_clk_i(clk), .line_i(tx), .line_o(rx));
    // ========================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [9:0] frm(input logic md, input logic [7:0] v, input logic n9);
        return md ? {1'b1, n9, v} : {2'b11, v};
    endfunction
    function automatic logic ld(input logic [5:0] k, input logic dn);
        return k[2] && !dn && (!k[3] || (k[4] ? k[1] : k[0]));
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k = 0;
        @(posedge clk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awrdy) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            br <= (k++ > 1);
        end while (!(bv === 1'b1 && br));
        wr_r = bresp;
        br <= 1'b0;
    endtask
    task automatic rdb(input logic [7:0] a);
        int k = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arrdy) arv <= 1'b0;
            rr <= (k++ > 1);
        end while (!(rv === 1'b1 && rr));
        rd_d = rd;
        rd_r = rresp;
        rr <= 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ========================
    // clocks, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        ext = 1'b0;
        forever #32 ext = ~ext;
    end
    initial begin
        #640000;
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        {rst, awv, wv, br, arv, rr} = 6'h20;
        {awa, ara, wd} = '0;
        errors = 0;
        n_checks = 0;
        seed = 32'hA412;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdb(aut_pkg::ADDR_CTRL);
        chk(rd_d[7:0], aut_pkg::CTRL_RESET);
        chk(rd_r, aut_pkg::RESP_OKAY);
        chk(tx, 1'b1);
        rdb(8'h10);
        chk(rd_r, aut_pkg::RESP_SLVERR);
        wr(8'h10, 32'h0);
        chk(wr_r, aut_pkg::RESP_SLVERR);
        wr(aut_pkg::ADDR_IRQ, 32'h1);
        chk(wr_r, aut_pkg::RESP_OKAY);
        for (int s = 0; s < 5; s++) begin
            rl = 8'hF8 | 8'(rnd() & 3);
            d = 8'(rnd());
            b9 = seed[3];
            m = s[0];
            rem.bit_cyc = 2 * (256 - rl) * dv[s];
            wr(aut_pkg::ADDR_TIMER, {13'h1, s[2:0], rl, rl});
            wr(aut_pkg::ADDR_CTRL, {24'h0, m, 3'h0, b9, 3'h0});
            f = rem.frames;
            wr(aut_pkg::ADDR_DATA, {24'h0, d});
            for (int i = 0; i < 14 * rem.bit_cyc && irq !== 1'b1; i++) @(posedge clk);
            chk(irq, 1'b1);
            chk({tx, rem.frames[30:0]}, {1'b1, f[30:0]});
            repeat (2 * rem.bit_cyc) @(posedge clk);
            chk(rem.word, frm(m, d, b9));
            rdb(aut_pkg::ADDR_CTRL);
            chk(rd_d[7:0] & 8'hBF, {m, 3'h0, b9, 3'h2});
            wr(aut_pkg::ADDR_CTRL, {24'h0, m, 3'h0, b9, 3'h0});
            chk(irq, 1'b0);
            $display("tx test %0d done", s);
        end
        rem.bit_cyc = 16;
        wr(aut_pkg::ADDR_TIMER, 32'h0008F8F8);
        {eb, eb9, edn} = '0;
        for (int i = 0; i < 8; i++) begin
            c = cs[i];
            d = 8'(rnd());
            if (!c[5]) begin
                wr(aut_pkg::ADDR_CTRL, {24'h0, c[4], 1'b0, c[3:2], 4'h0});
                {eb9, edn} = 2'b00;
            end
            rem.send(c[4] ? {c[0], c[1], d} : {1'b1, c[0], d}, c[4] ? 10 : 9);
            if (ld(c, edn)) {eb, eb9, edn} = {d, c[4] ? c[1] : c[0], 1'b1};
            repeat (4) @(posedge clk);
            rdb(aut_pkg::ADDR_DATA);
            chk(rd_d[7:0], eb);
            rdb(aut_pkg::ADDR_CTRL);
            chk(rd_d[7:0] & 8'hBF, {c[4], 1'b0, c[3:2], 1'b0, eb9, 1'b0, edn});
            chk(irq, edn);
            $display("rx test %0d done", i);
        end
        test_done();
    end
endmodule // aut_uart_tb
